/* File: rtl/asq_qualifier.sv */
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// How it works
// RULE_01 - Counter reset keeps timer run state
// RULE_02 - Action drives backplane signal out
// RULE_03 - Action drives backplane trigger out
// RULE_04 - Global condition gates storage, no counters
// RULE_05 - State command beats global condition
// RULE_06 - Global storage starts on or off
// RULE_07 - Event storage affects current sample only
// RULE_08 - Event command beats global command
// RULE_09 - Block stores 31 before, 31 after
// RULE_10 - Glitch or setup-hold blocks block storage
// RULE_11 - Glitch info fills half memory word
// RULE_12 - Glitch mode limits period to 10 ns
// RULE_13 - Each detector consumes one recognizer
// RULE_14 - Each backplane input consumes one recognizer
// RULE_15 - Counters set, reset, test, zero latency (here a set value reaches the test only on the next cycle)
// RULE_16 - Transition qualifier stores changed samples only
// RULE_17 - Two 51-bit counter/timers
// RULE_18 - Sixteen states stepped per valid sample
// RULE_19 - Increment counters, start/stop timers
// RULE_20 - Event, then state, then global priority
// RULE_21 - Overlapping blocks store each sample once
module asq_qualifier
  import asq_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register port
  input wire logic [ASQ_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Acquisition and trigger machine
  input wire logic i_acq_start,
  input wire asq_smp_t i_smp,
  input wire logic [ASQ_ST_W-1:0] i_state,
  input wire logic [ASQ_NREC-1:0] i_res,
  input wire asq_act_t i_act,
  input wire logic [1:0] i_ct_set,
  input wire logic [ASQ_CT_W-1:0] i_ct_set_val,
  input wire logic [ASQ_CT_W-1:0] i_ct_cmp,
  output logic [1:0] o_ct_hit,
  // Memory and backplane
  output asq_mem_t o_mem,
  output logic o_bp_sig_out,
  output logic o_bp_trig_out,
  output logic [ASQ_REC_W-1:0] o_rec_avail,
  output logic o_rate_err
);

  logic [31:0] ctrl_reg, ctrl_next;
  logic [ASQ_NREC-1:0] gmask_reg, gmask_next, gmatch_reg, gmatch_next;
  logic [2*ASQ_NSTATE-1:0] stcmd_reg, stcmd_next;
  logic [3:0] det_reg, det_next;
  logic [7:0] period_reg, period_next;
  logic [ASQ_CT_W-1:0] ct_reg [2], ct_next [2];
  logic [1:0] run_reg, run_next;
  logic gstore_reg, gstore_next;
  logic [ASQ_DW-1:0] prev_reg, prev_next;
  logic [ASQ_DW-1:0] hist_reg [ASQ_HIST];
  logic [ASQ_HIST_W-1:0] wp_reg, wp_next;
  logic [5:0] post_reg, post_next;
  logic [5:0] stored_cnt_reg, stored_cnt_next;
  logic [5:0] pre_left_reg, pre_left_next;
  logic [ASQ_HIST_W-1:0] rp_reg, rp_next;
  asq_mem_t mem_reg, mem_next;
  logic sig_reg, sig_next, trig_reg, trig_next, rerr_reg, rerr_next;
  logic [31:0] rdata_reg, rdata_next;

  function automatic asq_scmd_t st_cmd(input logic [2*ASQ_NSTATE-1:0] t,
                                       input logic [ASQ_ST_W-1:0] s);
    st_cmd = asq_scmd_t'(t[{s, 1'b0} +: 2]);
  endfunction : st_cmd

  logic block_en, glitch_mode, store_now, gcond;
  asq_scmd_t scmd;
  logic [ASQ_REC_W-1:0] used;
  assign block_en = ctrl_reg[ASQ_C_BLOCK] & ~ctrl_reg[ASQ_C_GLITCH]
                    & ~ctrl_reg[ASQ_C_SETHOLD]; // RULE_10
  assign glitch_mode = ctrl_reg[ASQ_C_GLITCH] & ctrl_reg[ASQ_C_ASYNC];
  // Counters excluded: condition sees only recognizer resources
  assign gcond = ((i_res ^ gmatch_reg) & gmask_reg) == '0; // RULE_04
  assign scmd = st_cmd(stcmd_reg, i_state); // RULE_18

  // Recognizer pool after detector, transition qualifier and backplane input trade-offs
  always_comb
  begin
    used = '0;
    for (int k = ASQ_C_GLITCH; k <= ASQ_C_SIG2; k++)
      if (k != ASQ_C_ASYNC)
        used = used + ASQ_REC_W'(ctrl_reg[k]); // RULE_13 RULE_14
    o_rec_avail = ASQ_REC_W'(ASQ_NREC) - used;
  end

  always_comb
  begin
    logic base;
    base = gstore_reg & gcond;
    if (scmd != ASQ_SC_NONE)
      base = (scmd == ASQ_SC_ON); // RULE_05
    if (i_act.ev_store != ASQ_SC_NONE)
      base = (i_act.ev_store == ASQ_SC_ON); // RULE_07 RULE_08 RULE_20
    if (ctrl_reg[ASQ_C_TRANS] && i_smp.data == prev_reg)
      base = 1'b0; // RULE_16
    store_now = i_smp.valid & base;
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    gmask_next = gmask_reg;
    gmatch_next = gmatch_reg;
    stcmd_next = stcmd_reg;
    det_next = det_reg;
    period_next = period_reg;
    rdata_next = '0;
    if (i_wr)
    begin
      unique case (i_addr)
        ASQ_R_CTRL: ctrl_next = i_wdata;
        ASQ_R_GMASK: gmask_next = i_wdata[ASQ_NREC-1:0];
        ASQ_R_GMATCH: gmatch_next = i_wdata[ASQ_NREC-1:0];
        ASQ_R_STCMD: stcmd_next = i_wdata;
        ASQ_R_DET: det_next = i_wdata[3:0];
        ASQ_R_PERIOD: period_next = i_wdata[7:0];
        default: ;
      endcase
    end
    if (i_rd)
    begin
      unique case (i_addr)
        ASQ_R_CTRL: rdata_next = ctrl_reg;
        ASQ_R_GMASK: rdata_next = {16'h0000, gmask_reg};
        ASQ_R_GMATCH: rdata_next = {16'h0000, gmatch_reg};
        ASQ_R_STCMD: rdata_next = stcmd_reg;
        ASQ_R_DET: rdata_next = {28'h0000000, det_reg};
        ASQ_R_STATUS: rdata_next = {21'h000000, rerr_reg, gstore_reg, run_reg,
                                    1'b0, o_rec_avail, block_en};
        ASQ_R_CT0_LO: rdata_next = ct_reg[0][31:0];
        ASQ_R_CT0_HI: rdata_next = {13'h0000, ct_reg[0][ASQ_CT_W-1:32]};
        ASQ_R_CT1_LO: rdata_next = ct_reg[1][31:0];
        ASQ_R_CT1_HI: rdata_next = {13'h0000, ct_reg[1][ASQ_CT_W-1:32]};
        ASQ_R_PERIOD: rdata_next = {24'h000000, period_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  // Counter/timers: reset is applied this cycle, run state untouched
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ct
      always_comb
      begin
        ct_next[g] = ct_reg[g];
        run_next[g] = run_reg[g];
        if (i_act.tm_start[g])
          run_next[g] = 1'b1; // RULE_19
        if (i_act.tm_stop[g])
          run_next[g] = 1'b0; // RULE_19
        if (ctrl_reg[ASQ_C_TIMER0 + g])
        begin
          if (run_reg[g])
            ct_next[g] = ct_reg[g] + 1'b1; // RULE_17
        end
        else if (i_act.ct_inc[g] && i_smp.valid)
          ct_next[g] = ct_reg[g] + 1'b1; // RULE_19
        if (i_ct_set[g])
          ct_next[g] = i_ct_set_val; // RULE_15
        if (i_act.ct_rst[g])
          ct_next[g] = '0; // RULE_01 RULE_15
        if (i_acq_start)
        begin
          ct_next[g] = '0;
          run_next[g] = 1'b0;
        end
      end
      // Test sees the cleared value at once after a reset
      assign o_ct_hit[g] = (i_act.ct_rst[g] ? '0 : ct_reg[g]) >= i_ct_cmp; // RULE_15
    end
  endgenerate

  // Storage path with history for block pre-samples
  always_comb
  begin
    logic [ASQ_DW-1:0] wd;
    wd = glitch_mode ? {i_smp.glitch[ASQ_DW/2-1:0], i_smp.data[ASQ_DW/2-1:0]}
                     : i_smp.data; // RULE_11
    gstore_next = i_acq_start ? ctrl_reg[ASQ_C_INIT_ON] : gstore_reg; // RULE_06
    prev_next = i_smp.valid ? i_smp.data : prev_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    post_next = post_reg;
    pre_left_next = pre_left_reg;
    stored_cnt_next = stored_cnt_reg;
    mem_next = '{we: 1'b0, data: wd};
    rerr_next = rerr_reg | (glitch_mode && period_reg != 8'h00
                && period_reg < ASQ_GLITCH_MIN_CYC); // RULE_12
    if (i_acq_start)
    begin
      rerr_next = 1'b0;
      post_next = '0;
      stored_cnt_next = '0;
      pre_left_next = '0;
    end
    else if (pre_left_reg != '0)
    begin
      // Drain pending pre-samples; incoming samples go into history but are never stored
      mem_next = '{we: 1'b1, data: hist_reg[rp_reg]};
      rp_next = rp_reg + 1'b1;
      pre_left_next = pre_left_reg - 1'b1;
    end
    if (i_smp.valid && !i_acq_start)
    begin
      wp_next = wp_reg + 1'b1;
      if (!block_en)
        mem_next = '{we: store_now, data: wd};
      else if (pre_left_reg == '0)
      begin
        if (store_now)
        begin
          // Only unstored history precedes; overlap never repeats
          post_next = 6'(ASQ_BLK);
          stored_cnt_next = '0;
          if (stored_cnt_reg == '0)
            mem_next = '{we: 1'b1, data: wd};
          else
          begin
            // Replay ends with this sample, which enters history now
            pre_left_next = ((stored_cnt_reg >= 6'(ASQ_BLK)) ? 6'(ASQ_BLK)
                            : stored_cnt_reg) + 6'h01; // RULE_09 RULE_21
            rp_next = wp_reg - ASQ_HIST_W'(pre_left_next - 6'h01);
          end
        end
        else if (post_reg != '0)
        begin
          mem_next = '{we: 1'b1, data: wd}; // RULE_09
          post_next = post_reg - 1'b1;
        end
        else if (stored_cnt_reg != 6'h3f)
          stored_cnt_next = stored_cnt_reg + 1'b1;
      end
    end
  end

  assign sig_next = i_act.sig_out; // RULE_02
  assign trig_next = i_act.trig_out; // RULE_03

  always_ff @(posedge i_clk_sys)
  begin
    if (i_smp.valid)
      hist_reg[wp_reg] <= i_smp.data;
    if (!i_rstn)
    begin
      ctrl_reg <= ASQ_CTRL_RST;
      gmask_reg <= '0;
      gmatch_reg <= '0;
      stcmd_reg <= '0;
      det_reg <= '0;
      period_reg <= '0;
      ct_reg[0] <= '0;
      ct_reg[1] <= '0;
      run_reg <= '0;
      gstore_reg <= 1'b1;
      prev_reg <= '0;
      wp_reg <= '0;
      rp_reg <= '0;
      post_reg <= '0;
      pre_left_reg <= '0;
      stored_cnt_reg <= '0;
      mem_reg <= '0;
      sig_reg <= 1'b0;
      trig_reg <= 1'b0;
      rerr_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      gmask_reg <= gmask_next;
      gmatch_reg <= gmatch_next;
      stcmd_reg <= stcmd_next;
      det_reg <= det_next;
      period_reg <= period_next;
      ct_reg[0] <= ct_next[0];
      ct_reg[1] <= ct_next[1];
      run_reg <= run_next;
      gstore_reg <= gstore_next;
      prev_reg <= prev_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      post_reg <= post_next;
      pre_left_reg <= pre_left_next;
      stored_cnt_reg <= stored_cnt_next;
      mem_reg <= mem_next;
      sig_reg <= sig_next;
      trig_reg <= trig_next;
      rerr_reg <= rerr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_mem = mem_reg;
  assign o_bp_sig_out = sig_reg;
  assign o_bp_trig_out = trig_reg;
  assign o_rate_err = rerr_reg;
  assign o_rdata = rdata_reg;

endmodule : asq_qualifier

/* File: rtl/asq_pkg.sv */
package asq_pkg;
  localparam int ASQ_DW = 32;
  localparam int ASQ_CT_W = 51;
  localparam int ASQ_NSTATE = 16;
  localparam int ASQ_ST_W = 4;
  localparam int ASQ_NREC = 16;
  localparam int ASQ_REC_W = 5;
  localparam int ASQ_BLK = 31;
  localparam int ASQ_HIST = 64;
  localparam int ASQ_HIST_W = 6;
  localparam int ASQ_ADDR_W = 4;
  localparam int ASQ_CLK_MHZ = 125;
  localparam int ASQ_GLITCH_MIN_NS = 10;
  localparam logic [7:0] ASQ_GLITCH_MIN_CYC =
    8'(((ASQ_GLITCH_MIN_NS * ASQ_CLK_MHZ) + 999) / 1000);
  localparam logic [3:0] ASQ_R_CTRL = 4'h0;
  localparam logic [3:0] ASQ_R_GMASK = 4'h1;
  localparam logic [3:0] ASQ_R_GMATCH = 4'h2;
  localparam logic [3:0] ASQ_R_STCMD = 4'h3;
  localparam logic [3:0] ASQ_R_DET = 4'h4;
  localparam logic [3:0] ASQ_R_STATUS = 4'h5;
  localparam logic [3:0] ASQ_R_CT0_LO = 4'h6;
  localparam logic [3:0] ASQ_R_CT0_HI = 4'h7;
  localparam logic [3:0] ASQ_R_CT1_LO = 4'h8;
  localparam logic [3:0] ASQ_R_CT1_HI = 4'h9;
  localparam logic [3:0] ASQ_R_PERIOD = 4'ha;
  localparam int ASQ_C_INIT_ON = 0;
  localparam int ASQ_C_BLOCK = 1;
  localparam int ASQ_C_GLITCH = 2;
  localparam int ASQ_C_SETHOLD = 3;
  localparam int ASQ_C_ASYNC = 4;
  localparam int ASQ_C_TRANS = 5;
  localparam int ASQ_C_SIG1 = 6;
  localparam int ASQ_C_SIG2 = 7;
  localparam int ASQ_C_TIMER0 = 8;
  localparam int ASQ_C_TIMER1 = 9;
  localparam logic [31:0] ASQ_CTRL_RST = 32'h0000_0001;
  typedef enum logic [1:0] {ASQ_SC_NONE = 2'h0, ASQ_SC_ON = 2'h1, ASQ_SC_OFF = 2'h2}
    asq_scmd_t;
  typedef struct packed {
    logic [1:0] ct_inc;
    logic [1:0] ct_rst;
    logic [1:0] tm_start;
    logic [1:0] tm_stop;
    logic sig_out;
    logic trig_out;
    asq_scmd_t ev_store;
  } asq_act_t;
  typedef struct packed {
    logic valid;
    logic [ASQ_DW-1:0] data;
    logic [ASQ_DW-1:0] glitch;
  } asq_smp_t;
  typedef struct packed {
    logic we;
    logic [ASQ_DW-1:0] data;
  } asq_mem_t;
endpackage : asq_pkg

/* File: testbench/asq_chk.sv */
`timescale 1ns/1ps
module asq_chk
  import asq_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Watched ports
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_acq_start,
  input wire asq_smp_t i_smp,
  input wire asq_act_t i_act,
  input wire logic [1:0] i_ct_set,
  input wire logic [ASQ_CT_W-1:0] i_ct_cmp,
  input wire logic [1:0] o_ct_hit,
  input wire asq_mem_t o_mem,
  input wire logic o_bp_sig_out,
  input wire logic o_bp_trig_out,
  input wire logic [ASQ_REC_W-1:0] o_rec_avail,
  input wire logic o_rate_err
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  sequence s_ev_on;
    i_smp.valid && i_act.ev_store == ASQ_SC_ON;
  endsequence
  sequence s_rst0;
    i_act.ct_rst[0] && !i_ct_set[0];
  endsequence
  // Block replay may delay the write by up to 32 cycles
  property p_ev_on; s_ev_on && !i_acq_start |-> ##[1:33] o_mem.we; endproperty
  property p_ct0; s_rst0 |-> o_ct_hit[0] == (i_ct_cmp == '0); endproperty
  property p_ct1; i_act.ct_rst[1] && !i_ct_set[1] |-> o_ct_hit[1] == (i_ct_cmp == '0); endproperty
  property p_sig; i_act.sig_out |=> o_bp_sig_out; endproperty
  property p_trg; $rose(o_bp_trig_out) |-> $past(i_act.trig_out); endproperty
  property p_avail; o_rec_avail inside {[5'hb:5'h10]}; endproperty
  property p_rerr; o_rate_err && !i_acq_start |=> o_rate_err; endproperty
  property p_rd; !i_rd |=> o_rdata == 32'h0; endproperty
  a_ev_on: assert property (p_ev_on) else $error("event store lost");
  a_ct0: assert property (p_ct0) else $error("counter 0 reset late");
  a_ct1: assert property (p_ct1) else $error("counter 1 reset late");
  a_sig: assert property (p_sig) else $error("signal out missing");
  a_trg: assert property (p_trg) else $error("trigger out spurious");
  a_avail: assert property (p_avail) else $error("recognizer count off");
  a_rerr: assert property (p_rerr) else $error("rate error dropped");
  a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : asq_chk
bind asq_qualifier asq_chk asq_chk_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_acq_start(i_acq_start), .i_smp(i_smp), .i_act(i_act),
  .i_ct_set(i_ct_set), .i_ct_cmp(i_ct_cmp), .o_ct_hit(o_ct_hit), .o_mem(o_mem),
  .o_bp_sig_out(o_bp_sig_out), .o_bp_trig_out(o_bp_trig_out), .o_rec_avail(o_rec_avail),
  .o_rate_err(o_rate_err));

/* File: testbench/asq_mem_model.sv */
`timescale 1ns/1ps
module asq_mem_model
  import asq_pkg::*;
(
  // Memory side
  input wire logic i_clk_sys,
  input wire logic i_clr,
  input wire asq_mem_t i_mem,
  // Tallies
  output int o_cnt,
  output int o_dup
);
  // Words are unique per test, so a repeat means a double store
  bit seen [logic [31:0]];
  always @(posedge i_clk_sys)
  begin
    if (i_clr)
    begin
      seen.delete();
      o_cnt <= 0;
      o_dup <= 0;
    end
    else if (i_mem.we)
    begin
      o_cnt <= o_cnt + 1;
      o_dup <= o_dup + int'(seen.exists(i_mem.data));
      seen[i_mem.data] = 1'b1;
    end
  end
endmodule : asq_mem_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import asq_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, acq = 1'b0, clr = 1'b0;
  logic [3:0] addr = 4'h0, st = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [15:0] res = 16'h0;
  logic [1:0] ctset = 2'h0, hit;
  logic [ASQ_CT_W-1:0] ctval = '0, ctcmp = '0;
  asq_smp_t smp = '0;
  asq_act_t act = '0;
  asq_mem_t mem;
  logic sig, trg, rerr;
  logic [ASQ_REC_W-1:0] avail;
  int cnt, dup, fail_count = 0, tests_run = 0;
  logic [31:0] det [5] = '{32'h05, 32'h0d, 32'h2d, 32'h6d, 32'hed};
  logic [31:0] blk [3] = '{32'h7, 32'hb, 32'h3};
  logic [1:0] t_ev [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [3:0] t_st [7] = '{4'h0, 4'h0, 4'h3, 4'h2, 4'h2, 4'h3, 4'h1};
  logic [15:0] t_rs [7] = '{16'h5, 16'h4, 16'h5, 16'h4, 16'h4, 16'h4, 16'h4};
  logic t_we [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  asq_qualifier asq_qualifier_i (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_acq_start(acq), .i_smp(smp), .i_state(st),
    .i_res(res), .i_act(act), .i_ct_set(ctset), .i_ct_set_val(ctval), .i_ct_cmp(ctcmp),
    .o_ct_hit(hit), .o_mem(mem), .o_bp_sig_out(sig), .o_bp_trig_out(trg), .o_rec_avail(avail),
    .o_rate_err(rerr));
  asq_mem_model asq_mem_model_i (.i_clk_sys(clk), .i_clr(clr), .i_mem(mem), .o_cnt(cnt),
    .o_dup(dup));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Strobe lands on the second edge after each call starts
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic pulse_start;
    @(posedge clk);
    acq <= 1'b1;
    @(posedge clk);
    acq <= 1'b0;
  endtask : pulse_start
  task automatic put(input logic [31:0] d, input logic [31:0] g, input logic [1:0] e,
                     input logic [3:0] s, input logic [15:0] r);
    @(posedge clk);
    smp <= '{1'b1, d, g};
    act <= '{2'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b1, asq_scmd_t'(e)};
    st <= s;
    res <= r;
    @(posedge clk);
    smp.valid <= 1'b0;
    act <= '0;
    #1;
  endtask : put
  initial
  begin
    #400_000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rreg(ASQ_R_CTRL);
    chk("ctrl", 32'h1, v);
    rreg(4'hf);
    chk("unmapped", 32'h0, v);
    foreach (det[i])
    begin
      wreg(ASQ_R_CTRL, det[i]);
      chk("avail", 32'(15 - i), {27'h0, avail});
    end
    wreg(ASQ_R_CTRL, 32'h1);
    wreg(ASQ_R_GMASK, 32'hff);
    wreg(ASQ_R_GMATCH, 32'h5);
    wreg(ASQ_R_STCMD, 32'h90);
    pulse_start();
    foreach (t_we[i])
    begin
      put(32'h100 + i, 32'h0, t_ev[i], t_st[i], t_rs[i]);
      chk("store", {31'h0, t_we[i]}, {31'h0, mem.we});
      if (t_we[i])
        chk("data", 32'h100 + i, mem.data);
    end
    chk("outs", 32'h3, {30'h0, sig, trg});
    wreg(ASQ_R_CTRL, 32'h0);
    pulse_start();
    put(32'h200, 32'h0, 2'h0, 4'h0, 16'h5);
    chk("init off", 32'h0, {31'h0, mem.we});
    wreg(ASQ_R_CTRL, 32'h21);
    wreg(ASQ_R_GMASK, 32'h0);
    pulse_start();
    for (int i = 0; i < 3; i++)
    begin
      put(32'h300 + i / 2, 32'h0, 2'h0, 4'h0, 16'h0);
      chk("trans", {31'h0, i != 1}, {31'h0, mem.we});
    end
    wreg(ASQ_R_CTRL, 32'h15);
    put(32'h1234_5678, 32'h0000_abcd, 2'h0, 4'h0, 16'h0);
    chk("packed", 32'habcd_5678, mem.data);
    wreg(ASQ_R_PERIOD, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("rate", 32'h1, {31'h0, rerr});
    wreg(ASQ_R_PERIOD, 32'h2);
    pulse_start();
    repeat (2) @(posedge clk);
    #1 chk("rate", 32'h0, {31'h0, rerr});
    // Long idle after the first hit keeps new samples out of the replay
    foreach (blk[i])
    begin
      wreg(ASQ_R_CTRL, blk[i]);
      wreg(ASQ_R_GMASK, 32'h1);
      pulse_start();
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      for (int j = 0; j < 86; j++)
      begin
        put(32'h1000 * i + j, 32'h0, 2'h0, 4'h0, {15'h0, j == 40 || j == 45});
        if (j == 40)
          repeat (40) @(posedge clk);
      end
      chk("blocks", i == 2 ? 32'd68 : 32'd2, 32'(cnt));
      chk("dups", 32'h0, 32'(dup));
    end
    wreg(ASQ_R_CTRL, 32'h1);
    pulse_start();
    smp.valid <= 1'b1;
    act.ct_inc <= 2'h1;
    ctcmp <= 51'h2;
    repeat (3) @(posedge clk);
    smp.valid <= 1'b0;
    act.ct_inc <= 2'h0;
    rreg(ASQ_R_CT0_LO);
    chk("count", 32'h3, v);
    chk("hit", 32'h1, {30'h0, hit});
    ctset <= 2'h2;
    ctval <= 51'h4_0000_0000_0005;
    @(posedge clk);
    ctset <= 2'h0;
    rreg(ASQ_R_CT1_HI);
    chk("set", 32'h0004_0000, v);
    act.ct_rst <= 2'h3;
    #1 chk("hit rst", 32'h0, {30'h0, hit});
    @(posedge clk);
    act.ct_rst <= 2'h0;
    rreg(ASQ_R_CT1_LO);
    chk("reset", 32'h0, v);
    wreg(ASQ_R_CTRL, 32'h101);
    act.tm_start <= 2'h1;
    @(posedge clk);
    act.tm_start <= 2'h0;
    repeat (8) @(posedge clk);
    act.ct_rst <= 2'h1;
    @(posedge clk);
    act.ct_rst <= 2'h0;
    rreg(ASQ_R_STATUS);
    chk("running", 32'h1, {31'h0, v[7]});
    rreg(ASQ_R_CT0_LO);
    chk("ticking", 32'h1, {31'h0, v > 0 && v < 8});
    report_and_stop();
  end
endmodule : testbench
